// ---- dv/flash_user_model.sv ----
// Purpose: User logic issuing flash requests
// Assumes: Ready sampled on rising edges
// Notes:   Lines scrambled once released
`timescale 1ns/1ps
module flash_user_model
  import user_flash_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic ready_i,
  output logic valid_o,
  output user_flash_pkg::flash_cmd_t cmd_o,
  output logic [8:0] addr_o,
  output logic [15:0] data_o
);
  initial begin
    valid_o = 1'b0;
    cmd_o = CMD_NONE;
    addr_o = 9'h0;
    data_o = 16'h0;
  end
  task issue(input flash_cmd_t c, input logic [8:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    valid_o = 1'b1;
    cmd_o = c;
    addr_o = a;
    data_o = d;
    do @(posedge sys_clk_i); while (ready_i !== 1'b1);
    @(negedge sys_clk_i);
    valid_o = 1'b0;
    cmd_o = CMD_NONE;
    addr_o = ~a;
    data_o = ~d;
  endtask
endmodule // flash_user_model

// ---- dv/tb_user_flash_block.sv ----
// Purpose: Self-checking bench for the flash store
// Assumes: Shortened pulse counts
// Notes:   Expected words worked out by hand
`timescale 1ns/1ps
module tb_user_flash_block;
  import user_flash_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic v, rdy, bsy, dn, rv;
  flash_cmd_t c;
  logic [8:0] a;
  logic [15:0] d, rd;
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  user_flash_block #(.ERASE_CYCLES(300), .PROG_CYCLES(5)) user_flash_block_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(v), .req_cmd_i(c), .req_addr_i(a),
    .req_data_i(d), .req_ready_o(rdy), .busy_o(bsy), .done_o(dn), .rd_valid_o(rv),
    .rd_data_o(rd));
  flash_user_model flash_user_model_i (.sys_clk_i(sys_clk_i), .ready_i(rdy), .valid_o(v),
    .cmd_o(c), .addr_o(a), .data_o(d));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Busy length counted on falling edges, done seen as busy drops
  task op(input flash_cmd_t cm, input logic [8:0] ad, input logic [15:0] da, input int n);
    int k;
    k = 0;
    flash_user_model_i.issue(cm, ad, da);
    chk({15'h0, rdy}, {15'h0, n == 0});
    while (bsy === 1'b1 && k < 999) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(16'(k), 16'(n));
    chk({15'h0, dn}, {15'h0, n != 0});
  endtask
  task rdw(input logic [8:0] ad, input logic [15:0] exp);
    op(CMD_READ, ad, 16'h0, 0);
    chk({rv, rd}, {1'b1, exp});
  endtask
  task t_erase;
    op(CMD_ERASE, 9'h000, 16'h0, 300);
    op(CMD_ERASE, 9'h1ff, 16'h0, 300);
    rdw(9'h000, 16'hffff);
    rdw(9'h1ff, 16'hffff);
  endtask
  task t_prog;
    op(CMD_PROGRAM, 9'h0ff, 16'h1234, 5);
    op(CMD_PROGRAM, 9'h100, 16'ha5a5, 5);
    rdw(9'h0ff, 16'h1234);
    rdw(9'h100, 16'ha5a5);
  endtask
  task t_keep;
    op(CMD_ERASE, 9'h000, 16'h0, 300);
    rdw(9'h0ff, 16'hffff);
    rdw(9'h100, 16'ha5a5);
    op(CMD_PROGRAM, 9'h0ff, 16'h0f0f, 5);
    rdw(9'h0ff, 16'h0f0f);
    op(CMD_ERASE, 9'h100, 16'h0, 300);
    rdw(9'h0ff, 16'h0f0f);
    rdw(9'h100, 16'hffff);
  endtask
  // Reset in mid-erase clears outputs but not the array
  task t_reset;
    flash_user_model_i.issue(CMD_ERASE, 9'h100, 16'h0);
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b1;
    @(negedge sys_clk_i);
    chk({12'h0, rdy, bsy, dn, rv}, 16'h0008);
    chk(rd, 16'h0000);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    rdw(9'h0ff, 16'h0f0f);
    flash_user_model_i.issue(CMD_NONE, 9'h0ff, 16'h0);
    chk({12'h0, rdy, bsy, dn, rv}, 16'h0008);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_erase();
    t_prog();
    t_keep();
    t_reset();
    finish_test();
  end
  initial begin
    #100us;
    n_mismatch++;
    finish_test();
  end
endmodule // tb_user_flash_block
bind user_flash_block user_flash_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
  .req_data_i(req_data_i), .req_ready_o(req_ready_o), .busy_o(busy_o), .done_o(done_o),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));

// ---- dv/user_flash_props.sv ----
// Purpose: Port assertions for the flash store
// Assumes: Erase 300 and program 5 cycles
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module user_flash_props
  import user_flash_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire user_flash_pkg::flash_cmd_t req_cmd_i,
  input wire logic [8:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic req_ready_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire tk = req_valid_i && req_ready_o;
  chk_read_answer: assert property (tk && req_cmd_i == CMD_READ |=> rd_valid_o)
    else $error("read not answered");
  chk_read_cause: assert property (rd_valid_o |-> $past(tk && req_cmd_i == CMD_READ))
    else $error("read data without request");
  chk_prog_time: assert property (tk && req_cmd_i == CMD_PROGRAM |=> busy_o[*5] ##1 done_o)
    else $error("program length wrong");
  chk_erase_hold: assert property (tk && req_cmd_i == CMD_ERASE |=> !req_ready_o[*8])
    else $error("ready during erase");
  chk_erase_done: assert property (tk && req_cmd_i == CMD_ERASE |=> ##300 done_o)
    else $error("erase length wrong");
  chk_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
    else $error("done too long");
  chk_rdata_hold: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved");
  chk_busy_cause: assert property ($rose(busy_o) |-> $past(tk))
    else $error("busy without request");
  cover property (tk && req_cmd_i == CMD_READ);
  cover property (tk && req_cmd_i == CMD_ERASE);
  cover property (tk && req_cmd_i == CMD_PROGRAM);
endmodule // user_flash_props

// ---- src/user_flash_block.sv ----
// Purpose: Two-sector user flash array with read, sector erase and word program
// Assumes: Requests come from logic on sys_clk_i
// Notes:   Pulse lengths are parameters so a simulation can shorten them
`timescale 1ns/1ps
`include "user_flash_defs.svh"

module user_flash_block
  import user_flash_pkg::*;
#(
  parameter int ADDR_W       = `UF_ADDR_W,
  parameter int DATA_W       = `UF_DATA_W,
  parameter int ERASE_CYCLES = `UF_ERASE_CYCLES,
  parameter int PROG_CYCLES  = `UF_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  // Request
  input  wire logic                    req_valid_i,
  input  wire user_flash_pkg::flash_cmd_t req_cmd_i,
  input  wire logic [ADDR_W-1:0]       req_addr_i,
  input  wire logic [DATA_W-1:0]       req_data_i,
  output logic                         req_ready_o,
  // Answer
  output logic                         busy_o,
  output logic                         done_o,
  output logic                         rd_valid_o,
  output logic [DATA_W-1:0]            rd_data_o
);

  import user_flash_pkg::*;

  localparam int WORDS     = 1 << ADDR_W;
  localparam int HALF      = WORDS / 2;
  localparam int CNT_W     = $clog2(ERASE_CYCLES + 1);

  // ===========================================================
  // Elaboration checks
  // Sector split and erase walk are built for the fixed array shape
  if (ADDR_W != `UF_ADDR_W || DATA_W != `UF_DATA_W) begin : gen_bad_shape
    $error("Array shape is fixed at 512 words of 16 bits");
  end
  if (WORDS * DATA_W != `UF_TOTAL_BITS || HALF * DATA_W != `UF_SECTOR_BITS) begin : gen_bad_geom
    $error("Sector geometry mismatch");
  end
  if (HALF - 1 != int'(`UF_SECTOR0_LAST) || HALF != int'(`UF_SECTOR1_FIRST) ||
      WORDS - 1 != int'(`UF_ADDR_LAST)) begin : gen_bad_map
    $error("Sector address map mismatch");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES > ERASE_CYCLES) begin : gen_bad_prog
    $error("Program pulse must be one cycle or more and not above erase");
  end
  // Erase wipes one word per cycle, so the pulse must cover a sector
  if (ERASE_CYCLES < HALF) begin : gen_bad_erase
    $error("Erase pulse shorter than the sector walk");
  end

  // ===========================================================
  // Storage
  // No reset on the array: flash contents survive a logic reset
  logic [DATA_W-1:0]  mem_reg [WORDS];
  flash_state_t       state_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [DATA_W-1:0]  data_reg;
  logic [ADDR_W-2:0]  wipe_idx_reg;
  // Request decode
  logic               accept;
  logic               take_read;
  logic               take_erase;
  logic               take_program;
  // Pulse and array addressing
  logic               pulse_end;
  logic               sector_sel;
  logic [ADDR_W-1:0]  wipe_addr;
  logic [DATA_W-1:0]  prog_word_next;

  // ===========================================================
  // Status and request decode
  assign req_ready_o  = (state_reg == ST_IDLE);
  assign busy_o       = (state_reg != ST_IDLE);
  // Code 3 is a no-op, so valid alone never starts anything
  assign accept       = req_valid_i && req_ready_o && (req_cmd_i != CMD_NONE);
  assign take_read    = accept && (req_cmd_i == CMD_READ);
  assign take_erase   = accept && (req_cmd_i == CMD_ERASE);
  assign take_program = accept && (req_cmd_i == CMD_PROGRAM);
  // Last cycle of a running pulse
  assign pulse_end    = (state_reg == ST_ERASE || state_reg == ST_PROGRAM) && (cnt_reg == '0);
  assign sector_sel   = addr_reg[`UF_SECTOR_BIT];
  assign wipe_addr    = {sector_sel, wipe_idx_reg};

  // ===========================================================
  // State
  // Reads finish in one cycle, so only erase and program leave idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take_erase) begin
            state_reg <= ST_ERASE;
          end else if (take_program) begin
            state_reg <= ST_PROGRAM;
          end
        end
        ST_ERASE, ST_PROGRAM: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          // Unused code: fall back to idle rather than hang
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // Pulse timer
  // Loaded with the length minus one, so busy lasts the whole pulse
  // Counts down to zero and rests there while idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (take_erase) begin
      cnt_reg <= CNT_W'(ERASE_CYCLES - 1);
    end else if (take_program) begin
      cnt_reg <= CNT_W'(PROG_CYCLES - 1);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // ===========================================================
  // Request capture
  // Reads capture too; only erase and program use the copy
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_reg <= '0;
      data_reg <= '0;
    end else if (accept) begin
      addr_reg <= req_addr_i;
      data_reg <= req_data_i;
    end
  end

  // ===========================================================
  // Completion pulse
  // Registered, so it stands in the cycle in which busy has dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= pulse_end;
    end
  end

  // ===========================================================
  // Array update
  // Erase walks one word per cycle within the chosen sector only;
  // the pulse is checked to be no shorter than the walk, so it ends in time
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wipe_idx_reg <= '0;
    end else if (state_reg == ST_ERASE) begin
      if (wipe_idx_reg != '1) begin
        wipe_idx_reg <= wipe_idx_reg + 1'b1;
      end
    end else begin
      wipe_idx_reg <= '0;
    end
  end

  // Flash cells only lose charge when programmed: bits can only clear
  // Read before the write edge, so the AND sees the old word
  always_comb begin
    prog_word_next = mem_reg[addr_reg] & data_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (state_reg == ST_ERASE) begin
      // Top address bit picks the sector; the other half is never touched
      mem_reg[wipe_addr] <= `UF_ERASED_WORD;
    end else if (state_reg == ST_PROGRAM && cnt_reg == '0) begin
      // Programming only clears bits, so an unerased word stays corrupt
      mem_reg[addr_reg] <= prog_word_next;
    end
  end

  // ===========================================================
  // Read path
  // Valid stands one cycle after the taking edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= take_read;
    end
  end

  // Data holds until the next read is taken
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (take_read) begin
      rd_data_o <= mem_reg[req_addr_i];
    end
  end

endmodule // user_flash_block

// ---- src/user_flash_defs.svh ----
// Purpose: Constants for the user flash sector store
// Assumes: 100 MHz system clock
// Notes:   Times in their own units, cycle counts derived
`ifndef USER_FLASH_DEFS_SVH
`define USER_FLASH_DEFS_SVH

`define UF_TOTAL_BITS      8192
`define UF_SECTOR_BITS     4096
`define UF_WORDS           512
`define UF_ADDR_W          9
`define UF_DATA_W          16
`define UF_SECTOR_BIT      8
`define UF_ADDR_LAST       9'h1ff
`define UF_SECTOR0_LAST    9'h0ff
`define UF_SECTOR1_FIRST   9'h100
`define UF_ERASED_WORD     16'hffff
`define UF_CLK_HZ          100000000
`define UF_ERASE_MS        500
`define UF_PROG_US         75
`define UF_ERASE_CYCLES    ((`UF_CLK_HZ / 1000) * `UF_ERASE_MS)
`define UF_PROG_CYCLES     ((`UF_CLK_HZ / 1000000) * `UF_PROG_US)

`endif

// ---- src/user_flash_pkg.sv ----
// Purpose: Types for the user flash sector store
// Assumes: Nothing beyond the defs header
// Notes:   Command and state encodings
package user_flash_pkg;

  typedef enum logic [1:0] {
    CMD_READ    = 2'h0,
    CMD_ERASE   = 2'h1,
    CMD_PROGRAM = 2'h2,
    CMD_NONE    = 2'h3
  } flash_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_ERASE   = 2'h1,
    ST_PROGRAM = 2'h2
  } flash_state_t;

endpackage
